// ### hdl/acs_regs.svh
// Register offsets, field positions, reset values and timing counts of the
// conversion sequencer. Assumes an 8-bit register port and a 100 MHz clk.
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// ==========================================================
// Register offsets
`define ACS_OFF_CTRL 8'h00
`define ACS_OFF_CFG 8'h01
`define ACS_OFF_STAT 8'h02
`define ACS_OFF_RESH 8'h03
`define ACS_OFF_RESL 8'h04

// ==========================================================
// Field positions and reset values
`define ACS_CTRL_EN 0
`define ACS_CTRL_GO 1
`define ACS_CFG_CLK_LSB 0
`define ACS_CFG_IE 3
`define ACS_STAT_DONE 0
`define ACS_STAT_PWR 1
`define ACS_STAT_SLPOFF 2
`define ACS_CLKSEL_RST 3'h0
`define ACS_RES_RST 10'h000
`define ACS_RES_BITS 10

// ==========================================================
// Timing
`define ACS_CLK_NS 10
`define ACS_INSTR_NS 40
`define ACS_INSTR_CYC ((`ACS_INSTR_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`define ACS_RC_TAD_NS 1600
`define ACS_RC_HALF_CYC (`ACS_RC_TAD_NS / 2 / `ACS_CLK_NS)
`define ACS_HALF_TOTAL 23
`define ACS_SAMPLE_HALF 3

`endif

// ### hdl/acs_pkg.sv
// Types shared by the conversion sequencer and its approximation register.
// Assumes acs_regs.svh is on the include path.
`include "acs_regs.svh"

package acs_pkg;

   // ==========================================================
   // Sequencer states
   typedef enum logic [2:0] {
      ACS_IDLE = 3'b001,
      ACS_DELAY = 3'b010,
      ACS_CONV = 3'b100
   } acs_state_t;

   // ==========================================================
   // Whole state of the sequencer
   typedef struct packed {
      acs_state_t state;
      logic en;
      logic go;
      logic [2:0] clk_sel;
      logic ie;
      logic done;
      logic slp_off;
      logic wake;
      logic [5:0] div_cnt;
      logic [7:0] rc_cnt;
      logic [2:0] dly_cnt;
      logic [4:0] hcnt;
      logic [9:0] result;
      logic [7:0] rdata;
      logic cs1;
      logic cs2;
      logic cs3;
      logic cmp;
   } acs_core_t;

   // ==========================================================
   // Whole state of the approximation register
   typedef struct packed {
      logic [9:0] code;
      logic [3:0] idx;
      logic [3:0] nres;
      logic last;
   } acs_sar_t;

endpackage : acs_pkg

// ### hdl/acs_sar.sv
// Successive approximation register: trial bits, resolution, partial fill.
// Assumes one step command per cycle from the sequencer on the same clock.
`timescale 1ns/10ps
`include "acs_regs.svh"

module acs_sar
   import acs_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic sar_clear,
   input wire logic sar_trial,
   input wire logic sar_resolve,
   input wire logic cmp_high,
   output logic [9:0] code,
   output logic [9:0] fill
);

   acs_sar_t q_r;
   acs_sar_t q_nxt;

   // ==========================================================
   // Step logic, most significant bit first
   always_comb begin
      q_nxt = q_r;
      if (sar_clear) begin
         q_nxt.code = `ACS_RES_RST;
         q_nxt.idx = 4'h9;
         q_nxt.nres = 4'h0;
         q_nxt.last = 1'b0;
      end else if (sar_trial) begin
         q_nxt.code[q_r.idx] = 1'b1;
      end else if (sar_resolve) begin
         q_nxt.code[q_r.idx] = cmp_high;
         q_nxt.last = cmp_high;
         q_nxt.nres = q_r.nres + 4'h1;
         q_nxt.idx = q_r.idx - 4'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q_r <= '{code: `ACS_RES_RST, idx: 4'h9, nres: 4'h0, last: 1'b0};
      end else begin
         q_r <= q_nxt;
      end
   end

   assign code = q_r.code;

   // ==========================================================
   // Unresolved positions take the most recently resolved value
   genvar i;
   generate
      for (i = 0; i < `ACS_RES_BITS; i = i + 1) begin : g_fill
         assign fill[i] = ((5'(i) + {1'b0, q_r.nres}) >= 5'h0A) ?
                          q_r.code[i] : q_r.last;
      end
   endgenerate

endmodule : acs_sar

// ### hdl/acs_top.sv
// Conversion sequencer of a 10-bit successive approximation converter:
// register port, start by software or compare trigger, completion,
// termination, sleep handling and the bit-period timing.
// Assumes the analog comparator output arrives asynchronously on cmp_in,
// and sleep_in and cmp_trigger come from logic on clk.
`timescale 1ns/10ps
`include "acs_regs.svh"

module acs_top
   import acs_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic sleep_in,
   input wire logic cmp_trigger,
   input wire logic cmp_in,
   output logic trigger_timer_clear,
   output logic converter_powered,
   output logic sample_hold,
   output logic [9:0] dac_trial,
   output logic conversion_done_flag,
   output logic wake_req
);

   // ==========================================================
   // Decoding helpers
   function automatic logic is_rc_sel(input logic [2:0] sel);
      return (sel[1:0] == 2'b11);
   endfunction : is_rc_sel

   // Half of one bit period, in clk cycles, for the divided sources
   function automatic logic [5:0] half_len(input logic [2:0] sel);
      logic [5:0] n;
      n = 6'h01;
      case (sel)
         3'b000: n = 6'h01;
         3'b100: n = 6'h02;
         3'b001: n = 6'h04;
         3'b101: n = 6'h08;
         3'b010: n = 6'h10;
         3'b110: n = 6'h20;
         default: n = 6'h01;
      endcase
      return n;
   endfunction : half_len

   localparam logic [7:0] RC_HALF_LAST = 8'(`ACS_RC_HALF_CYC - 1);
   localparam logic [2:0] INSTR_LAST = 3'(`ACS_INSTR_CYC - 1);
   localparam logic [4:0] HALF_TOTAL = 5'(`ACS_HALF_TOTAL);
   localparam logic [4:0] SAMPLE_HALF = 5'(`ACS_SAMPLE_HALF);

   acs_core_t q_r;
   acs_core_t q_nxt;

   // ==========================================================
   // Approximation register
   logic sar_clear;
   logic sar_trial;
   logic sar_resolve;
   logic [9:0] sar_code;
   logic [9:0] sar_fill;

   acs_sar u_sar (
      .clk(clk),
      .sys_rst(sys_rst),
      .sar_clear(sar_clear),
      .sar_trial(sar_trial),
      .sar_resolve(sar_resolve),
      .cmp_high(q_r.cmp),
      .code(sar_code),
      .fill(sar_fill)
   );

   // ==========================================================
   // Decoded bus accesses
   logic wr_ctrl;
   logic wr_cfg;
   logic wr_stat;
   logic en_new;
   logic rc_mode;
   logic rc_tick;
   logic half_tick;
   logic [4:0] hcnt_inc;
   logic start_req;
   logic sw_stop;
   logic abort;
   logic sleep_abort;
   logic complete;
   logic done_set;
   logic done_clr;
   logic busy;

   assign wr_ctrl = reg_wr && (reg_addr == `ACS_OFF_CTRL);
   assign wr_cfg = reg_wr && (reg_addr == `ACS_OFF_CFG);
   assign wr_stat = reg_wr && (reg_addr == `ACS_OFF_STAT);
   assign busy = (q_r.state != ACS_IDLE);
   assign rc_mode = is_rc_sel(q_r.clk_sel);

   // ==========================================================
   // Next state
   always_comb begin
      q_nxt = q_r;
      sar_clear = 1'b0;
      sar_trial = 1'b0;
      sar_resolve = 1'b0;
      complete = 1'b0;
      done_set = 1'b0;

      // Comparator sync; value moves only when stages two and three agree
      q_nxt.cs1 = cmp_in;
      q_nxt.cs2 = q_r.cs1;
      q_nxt.cs3 = q_r.cs2;
      if (q_r.cs2 == q_r.cs3) begin
         q_nxt.cmp = q_r.cs3;
      end

      // Free running divider of the dedicated RC source
      rc_tick = (q_r.rc_cnt == RC_HALF_LAST);
      q_nxt.rc_cnt = rc_tick ? 8'h00 : q_r.rc_cnt + 8'h01;

      // Configuration; changing the source mid conversion is not guarded
      if (wr_cfg) begin
         q_nxt.clk_sel = reg_wdata[`ACS_CFG_CLK_LSB +: 3];
         q_nxt.ie = reg_wdata[`ACS_CFG_IE];
      end

      en_new = wr_ctrl ? reg_wdata[`ACS_CTRL_EN] : q_r.en;
      q_nxt.en = en_new;

      // Start when enabled and not switched off by sleep
      start_req = !busy && en_new && !q_r.slp_off &&
                  ((wr_ctrl && reg_wdata[`ACS_CTRL_GO]) || cmp_trigger);
      sw_stop = busy && wr_ctrl && !reg_wdata[`ACS_CTRL_GO];
      sleep_abort = sleep_in && !rc_mode;
      abort = busy && (!en_new || sleep_abort);

      // Bit period timing in half periods
      if (rc_mode) begin
         half_tick = rc_tick;
      end else begin
         half_tick = (q_r.div_cnt == (half_len(q_r.clk_sel) - 6'h01));
      end
      hcnt_inc = q_r.hcnt + 5'h01;

      // Sleep power handling; enable bit itself is left untouched
      if (sleep_abort) begin
         q_nxt.slp_off = 1'b1;
      end
      if (!sleep_in) begin
         q_nxt.slp_off = 1'b0;
         q_nxt.wake = 1'b0;
      end

      case (q_r.state)
         ACS_IDLE: begin
            if (start_req) begin
               q_nxt.go = 1'b1;
               sar_clear = 1'b1;
               q_nxt.div_cnt = 6'h00;
               q_nxt.hcnt = 5'h00;
               q_nxt.dly_cnt = 3'h0;
               if (rc_mode) begin
                  q_nxt.state = ACS_DELAY;
               end else begin
                  q_nxt.state = ACS_CONV;
               end
            end else begin
               q_nxt.go = 1'b0;
            end
         end
         ACS_DELAY: begin
            // Extra instruction cycle lets the core reach sleep first
            if (abort) begin
               q_nxt.go = 1'b0;
               q_nxt.state = ACS_IDLE;
            end else if (sw_stop) begin
               q_nxt.go = 1'b0;
               q_nxt.result = sar_fill;
               q_nxt.state = ACS_IDLE;
            end else if (q_r.dly_cnt == INSTR_LAST) begin
               q_nxt.state = ACS_CONV;
               // Restart the RC divider so the first half period is a full one
               q_nxt.rc_cnt = 8'h00;
            end else begin
               q_nxt.dly_cnt = q_r.dly_cnt + 3'h1;
            end
         end
         ACS_CONV: begin
            if (half_tick) begin
               q_nxt.div_cnt = 6'h00;
               q_nxt.hcnt = hcnt_inc;
            end else begin
               q_nxt.div_cnt = q_r.div_cnt + 6'h01;
            end
            // Trial bit on odd half ticks, resolution on even ones
            if (half_tick && hcnt_inc >= SAMPLE_HALF && hcnt_inc < HALF_TOTAL) begin
               if (hcnt_inc[0]) begin
                  sar_trial = 1'b1;
               end else begin
                  sar_resolve = 1'b1;
               end
            end
            complete = half_tick && (hcnt_inc == HALF_TOTAL);
            if (abort) begin
               // Enable loss or sleep abort leaves the results untouched
               q_nxt.go = 1'b0;
               q_nxt.state = ACS_IDLE;
            end else if (complete) begin
               // Completion beats a termination written in the same cycle
               q_nxt.go = 1'b0;
               done_set = 1'b1;
               q_nxt.result = sar_code;
               q_nxt.state = ACS_IDLE;
               if (sleep_in && q_r.ie) begin
                  q_nxt.wake = 1'b1;
               end
               if (sleep_in && !q_r.ie) begin
                  q_nxt.slp_off = 1'b1;
               end
            end else if (sw_stop) begin
               q_nxt.go = 1'b0;
               q_nxt.result = sar_fill;
               q_nxt.state = ACS_IDLE;
            end
         end
         default: begin
            q_nxt.state = ACS_IDLE;
            q_nxt.go = 1'b0;
         end
      endcase

      // Hardware sets, software clears by writing one; set wins
      done_clr = wr_stat && reg_wdata[`ACS_STAT_DONE];
      q_nxt.done = (q_r.done && !done_clr) || done_set;

      // Read data stands in the cycle after the strobe only
      q_nxt.rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            `ACS_OFF_CTRL: begin
               q_nxt.rdata = {6'h00, q_r.go, q_r.en};
            end
            `ACS_OFF_CFG: begin
               q_nxt.rdata = {4'h0, q_r.ie, q_r.clk_sel};
            end
            `ACS_OFF_STAT: begin
               q_nxt.rdata = {5'h00, q_r.slp_off, converter_powered, q_r.done};
            end
            `ACS_OFF_RESH: begin
               q_nxt.rdata = {6'h00, q_r.result[9:8]};
            end
            `ACS_OFF_RESL: begin
               q_nxt.rdata = q_r.result[7:0];
            end
            default: begin
               q_nxt.rdata = 8'h00;
            end
         endcase
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         // Every field returns to its reset value; conversion ends
         q_r <= '{
            state: ACS_IDLE,
            en: 1'b0,
            go: 1'b0,
            clk_sel: `ACS_CLKSEL_RST,
            ie: 1'b0,
            done: 1'b0,
            slp_off: 1'b0,
            wake: 1'b0,
            div_cnt: 6'h00,
            rc_cnt: 8'h00,
            dly_cnt: 3'h0,
            hcnt: 5'h00,
            result: `ACS_RES_RST,
            rdata: 8'h00,
            cs1: 1'b0,
            cs2: 1'b0,
            cs3: 1'b0,
            cmp: 1'b0
         };
      end else begin
         q_r <= q_nxt;
      end
   end

   // ==========================================================
   // Outputs
   // Timer clear follows the trigger in the same cycle, one cycle before go reads as set
   assign trigger_timer_clear = cmp_trigger;
   assign converter_powered = q_r.en && !q_r.slp_off;
   assign sample_hold = (q_r.state == ACS_CONV);
   assign dac_trial = sar_code;
   assign conversion_done_flag = q_r.done;
   assign wake_req = q_r.wake;
   assign reg_rdata = q_r.rdata;

endmodule : acs_top

// ### testbench/acs_top_props.sv
// Concurrent checks on the conversion sequencer ports: start, completion, sleep, trigger.
// Assumes it is bound into acs_top and sees only that module's ports.
`timescale 1ns/10ps
`include "acs_regs.svh"

module acs_top_chk
   import acs_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic sleep_in,
   input wire logic cmp_trigger,
   input wire logic trigger_timer_clear,
   input wire logic converter_powered,
   input wire logic sample_hold,
   input wire logic conversion_done_flag,
   input wire logic wake_req
);
   // ==========================================================
   // Helper logic
   // Clock source as last written; a write mid-conversion is not modelled
   logic rc_sel_r;
   logic ctrl_wr;
   logic go_wr;
   logic idle_ok;
   assign ctrl_wr = reg_wr && reg_addr == `ACS_OFF_CTRL;
   assign go_wr = ctrl_wr && reg_wdata[1:0] == 2'b11;
   assign idle_ok = converter_powered && !sample_hold && !sleep_in;

   always_ff @(posedge clk) begin
      if (sys_rst)
         rc_sel_r <= 1'b0;
      else if (reg_wr && reg_addr == `ACS_OFF_CFG)
         rc_sel_r <= &reg_wdata[1:0];
   end

   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   // ==========================================================
   // Properties
   property p_timer_clear;
      trigger_timer_clear == cmp_trigger;
   endproperty
   a_timer_clear: assert property (p_timer_clear) else $error("timer clear wrong");

   property p_trig_start;
      cmp_trigger && idle_ok && !rc_sel_r && !reg_wr |=> sample_hold;
   endproperty
   a_trig_start: assert property (p_trig_start) else $error("trigger no start");

   property p_sw_start;
      go_wr && idle_ok && !rc_sel_r && !cmp_trigger |=> sample_hold;
   endproperty
   a_sw_start: assert property (p_sw_start) else $error("go write no start");

   property p_rc_delay;
      go_wr && idle_ok && rc_sel_r |=> !sample_hold [*3] ##[1:3] sample_hold;
   endproperty
   a_rc_delay: assert property (p_rc_delay) else $error("rc start delay wrong");

   property p_en_off;
      ctrl_wr && !reg_wdata[0] |=> !converter_powered && !sample_hold;
   endproperty
   a_en_off: assert property (p_en_off) else $error("disabled but active");

   property p_done_hold;
      conversion_done_flag && !(reg_wr && reg_addr == `ACS_OFF_STAT && reg_wdata[0])
         |=> conversion_done_flag;
   endproperty
   a_done_hold: assert property (p_done_hold) else $error("done flag lost");

   property p_done_rise;
      $rose(conversion_done_flag) |-> $fell(sample_hold);
   endproperty
   a_done_rise: assert property (p_done_rise) else $error("done not at end");

   property p_sleep_abort;
      sleep_in && !rc_sel_r |=> !sample_hold && !converter_powered;
   endproperty
   a_sleep_abort: assert property (p_sleep_abort) else $error("sleep no abort");

   property p_wake;
      $rose(wake_req) |-> sleep_in && conversion_done_flag && $fell(sample_hold);
   endproperty
   a_wake: assert property (p_wake) else $error("wake without completion");

   c_done: cover property ($rose(conversion_done_flag));
   c_wake: cover property ($rose(wake_req));
   c_trig: cover property (cmp_trigger && idle_ok);
endmodule : acs_top_chk

bind acs_top acs_top_chk chk_u (
   .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .sleep_in(sleep_in), .cmp_trigger(cmp_trigger),
   .trigger_timer_clear(trigger_timer_clear), .converter_powered(converter_powered),
   .sample_hold(sample_hold), .conversion_done_flag(conversion_done_flag),
   .wake_req(wake_req)
);

// ### testbench/acs_top_test.sv
// Self-checking bench for the conversion sequencer top.
// Assumes acs_pkg, acs_sar, acs_top and the checker are compiled first.
`timescale 1ns/10ps
`include "acs_regs.svh"

module acs_top_test
   import acs_pkg::*;
();
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic reg_wr = 1'b0, reg_rd = 1'b0, sleep_in = 1'b0, cmp_trigger = 1'b0, cmp_in = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic [9:0] dac_trial;
   logic trigger_timer_clear, converter_powered, sample_hold, conversion_done_flag, wake_req;
   int miscompares = 0;
   int comparisons = 0;

   acs_top dut_u (
      .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_in(sleep_in),
      .cmp_trigger(cmp_trigger), .cmp_in(cmp_in), .trigger_timer_clear(trigger_timer_clear),
      .converter_powered(converter_powered), .sample_hold(sample_hold),
      .dac_trial(dac_trial), .conversion_done_flag(conversion_done_flag), .wake_req(wake_req)
   );

   initial begin
      forever #5 clk = ~clk;
   end

   // ==========================================================
   // Bus and compare tasks
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic ok(input logic c);
      chk({9'h000, c}, 10'h001);
   endtask : ok

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask : wr

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk({2'b00, reg_rdata}, {2'b00, exp});
      @(posedge clk);
   endtask : rdchk

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : wait_cyc

   // Counts edges until sample_hold reaches v, bounded
   task automatic wait_lvl(input logic v, output int n);
      n = 0;
      #1;
      while (sample_hold !== v && n < 3000) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask : wait_lvl

   // Enable in one write, start in the next
   task automatic start(input logic [7:0] cfg);
      wr(`ACS_OFF_CFG, cfg);
      wr(`ACS_OFF_CTRL, 8'h01);
      wr(`ACS_OFF_CTRL, 8'h03);
   endtask : start

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      sys_rst <= 1'b1;
      wait_cyc(10);
      sys_rst <= 1'b0;
      @(posedge clk);
      for (int a = 0; a < 8; a++) rdchk(8'(a), 8'h00);
      wr(`ACS_OFF_CTRL, 8'h02);
      rdchk(`ACS_OFF_CTRL, 8'h00);
   endtask : t_reset

   task automatic t_dividers();
      logic [2:0] sels [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
      int n;
      for (int i = 0; i < 6; i++) begin
         cmp_in <= i[0];
         start({5'h00, sels[i]});
         wait_lvl(1'b0, n);
         ok(n + 1 >= 23 << i && n + 1 <= (23 << i) + 2);
         chk(dac_trial, {10{i[0]}});
         rdchk(`ACS_OFF_RESH, {6'h00, {2{i[0]}}});
         rdchk(`ACS_OFF_RESL, {8{i[0]}});
         rdchk(`ACS_OFF_STAT, 8'h03);
         rdchk(`ACS_OFF_CTRL, 8'h01);
         wr(`ACS_OFF_STAT, 8'h00);
         rdchk(`ACS_OFF_STAT, 8'h03);
         wr(`ACS_OFF_STAT, 8'h01);
         rdchk(`ACS_OFF_STAT, 8'h02);
      end
   endtask : t_dividers

   // First bit resolves high, second low, then software stops it
   task automatic t_term();
      cmp_in <= 1'b1;
      start(8'h06);
      rdchk(`ACS_OFF_CTRL, 8'h03);
      rdchk(`ACS_OFF_RESL, 8'hFF);
      wait_cyc(154);
      cmp_in <= 1'b0;
      wait_cyc(70);
      wr(`ACS_OFF_CTRL, 8'h01);
      rdchk(`ACS_OFF_RESH, 8'h02);
      rdchk(`ACS_OFF_RESL, 8'h00);
      rdchk(`ACS_OFF_STAT, 8'h02);
   endtask : t_term

   task automatic t_trig();
      int n;
      cmp_in <= 1'b0;
      wr(`ACS_OFF_CFG, 8'h00);
      cmp_trigger <= 1'b1;
      #1;
      ok(trigger_timer_clear);
      @(posedge clk);
      cmp_trigger <= 1'b0;
      rdchk(`ACS_OFF_CTRL, 8'h03);
      cmp_trigger <= 1'b1;
      @(posedge clk);
      cmp_trigger <= 1'b0;
      wait_lvl(1'b0, n);
      ok(n + 3 >= 23 && n + 3 <= 25);
      rdchk(`ACS_OFF_RESH, 8'h00);
      rdchk(`ACS_OFF_STAT, 8'h03);
      wr(`ACS_OFF_STAT, 8'h01);
   endtask : t_trig

   task automatic t_sleep();
      start(8'h06);
      wait_cyc(10);
      sleep_in <= 1'b1;
      wait_cyc(3);
      #1;
      ok(!sample_hold && !converter_powered);
      rdchk(`ACS_OFF_CTRL, 8'h01);
      rdchk(`ACS_OFF_STAT, 8'h04);
      sleep_in <= 1'b0;
      wait_cyc(2);
      #1;
      ok(converter_powered);
   endtask : t_sleep

   task automatic t_rc(input logic ie);
      int n;
      cmp_in <= 1'b1;
      start({4'h0, ie, 3'h3});
      wait_lvl(1'b1, n);
      ok(n >= 3 && n <= 5);
      sleep_in <= 1'b1;
      wait_lvl(1'b0, n);
      ok(n >= 1836 && n <= 1844);
      ok(conversion_done_flag && wake_req === ie && converter_powered === ie);
      rdchk(`ACS_OFF_CTRL, 8'h01);
      rdchk(`ACS_OFF_STAT, {5'h00, !ie, ie, 1'b1});
      sleep_in <= 1'b0;
      wait_cyc(2);
      #1;
      ok(!wake_req && converter_powered);
      wr(`ACS_OFF_STAT, 8'h01);
   endtask : t_rc

   task automatic test_done();
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : test_done

   // ==========================================================
   // Sequence and watchdog
   initial begin
      t_reset();
      t_dividers();
      t_term();
      t_trig();
      t_sleep();
      t_rc(1'b1);
      t_rc(1'b0);
      start(8'h06);
      wait_cyc(20);
      t_reset();
      ok(!sample_hold);
      test_done();
   end

   // Whole run needs about 6000 cycles
   initial begin
      wait_cyc(20000);
      miscompares++;
      test_done();
   end
endmodule : acs_top_test
